// ==== shared/tcc_defines.svh ====
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave
`define TCC_OFS_MODE        5'h00
`define TCC_OFS_CAPMODE     5'h04
`define TCC_OFS_OUTCTL      5'h08
`define TCC_OFS_PRESCALE    5'h0C
`define TCC_OFS_CAPCMP0     5'h10
`define TCC_OFS_CAPCMP1     5'h14
`define TCC_OFS_COUNTER     5'h18

// timer_mode_control fields
`define TCC_MODE_LSB        0
`define TCC_MODE_MSB        1
`define TCC_MODE_OVF        4

// capture_mode_control fields
`define TCC_CAP_R0_SEL      0
`define TCC_CAP_R0_REV      1
`define TCC_CAP_R1_SEL      2

// output_control fields
`define TCC_OUT_EN          0
`define TCC_OUT_TGL0        1
`define TCC_OUT_LVR         2
`define TCC_OUT_LVS         3
`define TCC_OUT_TGL1        4
`define TCC_OUT_STORED_MASK 8'h13

// prescaler_mode fields
`define TCC_PRM_CLK_LO      0
`define TCC_PRM_CLK_HI      1
`define TCC_PRM_ESA_LO      4
`define TCC_PRM_ESA_HI      5
`define TCC_PRM_ESB_LO      6
`define TCC_PRM_ESB_HI      7
`define TCC_PRM_STORED_MASK 8'hF3

// Edge select codes
`define TCC_ES_FALL         2'h0
`define TCC_ES_RISE         2'h1
`define TCC_ES_BOTH         2'h3

// Prescaler tap masks for divide by 2, 16 and 128
`define TCC_DIV2_MASK       7'h01
`define TCC_DIV16_MASK      7'h0F
`define TCC_DIV128_MASK     7'h7F

// Reset values
`define TCC_RST_CTRL        8'h00
`define TCC_RST_WORD        16'h0000

`endif

// ==== shared/tcc_pkg.sv ====
package tcc_pkg;

  typedef enum logic [1:0] {
    tcc_mode_stop,
    tcc_mode_free,
    tcc_mode_clear,
    tcc_mode_restart
  } tcc_mode_t;

  typedef enum logic [1:0] {
    tcc_clk_div2,
    tcc_clk_div16,
    tcc_clk_div128,
    tcc_clk_pin
  } tcc_clk_sel_t;

endpackage : tcc_pkg

// ==== shared/tcc_edge_if.sv ====
`timescale 1ns/1ns

interface tcc_edge_if;
  logic       sample_tick;
  logic [1:0] pin;
  logic [1:0] rise;
  logic [1:0] fall;

  modport det (input sample_tick, input pin, output rise, output fall);
  modport ctl (output sample_tick, output pin, input rise, input fall);
endinterface : tcc_edge_if

// ==== hdl/tcc_edge_detect.sv ====
`timescale 1ns/1ns

module tcc_edge_detect #(
  parameter int CHANNELS = 2
) (
  input wire logic   clk_sys,
  input wire logic   nrst,
  tcc_edge_if.det    eif
);

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      logic smp_new;
      logic smp_old;
      logic level;
      wire  agree   = (smp_new == smp_old);
      wire  changed = agree & (smp_old != level);

      // Level only moves after two matching samples; shorter pulses are ignored [R8]
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          smp_new <= 1'b0;
          smp_old <= 1'b0;
          level   <= 1'b0;
        end
        else if (eif.sample_tick)
        begin
          smp_new <= eif.pin[ch];
          smp_old <= smp_new;
          if (changed)
            level <= smp_old;
        end
      end

      assign eif.rise[ch] = eif.sample_tick & changed & smp_old;   // [R8]
      assign eif.fall[ch] = eif.sample_tick & changed & ~smp_old;  // [R8]
    end
  endgenerate

endmodule : tcc_edge_detect

// ==== hdl/tcc_top.sv ====
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "tcc_defines.svh"

// Overview of operation
// R1 - Interval mode: match on register zero clears counter, keeps counting, pulses irq zero.
// R2 - Interval equals compare value plus one count clocks, for any 16-bit value.
// R3 - Count clock source comes from the two low prescaler bits.
// R4 - Pulse mode: period from register zero, high width from register one.
// R5 - Software keeps register one strictly below register zero in pulse mode.
// R6 - Pulse period is value zero plus one; duty is (one+1)/(zero+1).
// R7 - Free running: valid edge on input a captures counter into register one, irq one.
// R8 - Inputs sampled at count clock; new level needs two equal samples. In pin clock mode the code samples at system clock over 2.
// R9 - Two-input mode: input a edge, select bits 4-5, captures into register one.
// R10 - Two-input mode: input b edge, select bits 6-7, captures into register zero.
// R11 - Edge detectors support rising, falling or both edges.
// R12 - Two-register mode: opposite edge of input a captures into register zero.
// R13 - Two-register and restart modes: both-edge select disables register zero capture.
// R14 - Restart mode: input a edge captures into register one then clears counter.
// R15 - Edge field: 00 falling, 01 rising, 11 both, 10 prohibited.
// R16 - Clock select: system clock over 2, 16, 128, or input a edge.
// R17 - Mode bit makes register zero a compare (0) or capture (1) register.
// R18 - With toggle enable set, output flip-flop toggles on register zero match.
// R19 - Each interrupt request is one pulse per match or capture event.

module tcc_top (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        capture_input_a,
  input  wire logic        capture_input_b,
  output logic             pulse_output_pin,
  output logic             pulse_output_en,
  output logic             irq_capcmp_zero,
  output logic             irq_capcmp_one
);

  tcc_edge_if eif ();

  tcc_pkg::tcc_mode_t    mode;
  tcc_pkg::tcc_clk_sel_t clk_sel;

  logic [1:0]  timer_mode_control;
  logic        overflow;
  logic [2:0]  capture_mode_control;
  logic [7:0]  output_control;
  logic [7:0]  prescaler_mode;
  logic [15:0] capcmp_reg_zero;
  logic [15:0] capcmp_reg_one;
  logic [15:0] up_counter;
  logic [6:0]  prediv;
  logic        out_ff;
  logic        rd_ack;

  logic [15:0] next_counter;
  logic        next_out_ff;
  logic [31:0] rd_mux;

  // Bus decode
  wire bus_wr      = avs_write & ~avs_read;
  wire wr_mode     = bus_wr & (avs_address == `TCC_OFS_MODE);
  wire wr_capmode  = bus_wr & (avs_address == `TCC_OFS_CAPMODE);
  wire wr_outctl   = bus_wr & (avs_address == `TCC_OFS_OUTCTL);
  wire wr_prescale = bus_wr & (avs_address == `TCC_OFS_PRESCALE);
  wire wr_capcmp0  = bus_wr & (avs_address == `TCC_OFS_CAPCMP0);
  wire wr_capcmp1  = bus_wr & (avs_address == `TCC_OFS_CAPCMP1);

  assign mode    = tcc_pkg::tcc_mode_t'(timer_mode_control);
  assign clk_sel = tcc_pkg::tcc_clk_sel_t'(
                     {prescaler_mode[`TCC_PRM_CLK_HI], prescaler_mode[`TCC_PRM_CLK_LO]});

  wire [1:0] es_a = {prescaler_mode[`TCC_PRM_ESA_HI], prescaler_mode[`TCC_PRM_ESA_LO]};
  wire [1:0] es_b = {prescaler_mode[`TCC_PRM_ESB_HI], prescaler_mode[`TCC_PRM_ESB_LO]};

  wire running     = (mode != tcc_pkg::tcc_mode_stop);
  wire mode_clear  = (mode == tcc_pkg::tcc_mode_clear);
  wire mode_rstrt  = (mode == tcc_pkg::tcc_mode_restart);
  wire r0_capture  = capture_mode_control[`TCC_CAP_R0_SEL];
  wire r0_reverse  = capture_mode_control[`TCC_CAP_R0_REV];
  wire r1_capture  = capture_mode_control[`TCC_CAP_R1_SEL];

  // Prescaler taps
  // Taps free-run, so the first count after a start may come up to one period early
  wire tap2   = ((prediv & `TCC_DIV2_MASK) == `TCC_DIV2_MASK);
  wire tap16  = ((prediv & `TCC_DIV16_MASK) == `TCC_DIV16_MASK);
  wire tap128 = ((prediv & `TCC_DIV128_MASK) == `TCC_DIV128_MASK);

  wire div_tick = (clk_sel == tcc_pkg::tcc_clk_div2)  ? tap2  :     // [R16]
                  (clk_sel == tcc_pkg::tcc_clk_div16) ? tap16 :     // [R16]
                  (clk_sel == tcc_pkg::tcc_clk_div128) ? tap128 :   // [R16]
                  tap2;

  // Pin clock mode still needs a sampling rate; the fastest tap keeps latency low
  assign eif.sample_tick = div_tick;
  assign eif.pin         = {capture_input_b, capture_input_a};

  tcc_edge_detect #(
    .CHANNELS (2)
  ) u_edge (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .eif     (eif)
  );

  // Edge decode: code 10 selects nothing
  function automatic logic edge_valid(input logic [1:0] es, input logic rise,
                                      input logic fall);
    case (es)
      `TCC_ES_FALL: edge_valid = fall;           // [R15]
      `TCC_ES_RISE: edge_valid = rise;           // [R15]
      `TCC_ES_BOTH: edge_valid = rise | fall;    // [R11] [R15]
      default:      edge_valid = 1'b0;
    endcase
  endfunction : edge_valid

  // Opposite edge exists only for a single-edge selection
  function automatic logic edge_opposite(input logic [1:0] es, input logic rise,
                                         input logic fall);
    case (es)
      `TCC_ES_FALL: edge_opposite = rise;
      `TCC_ES_RISE: edge_opposite = fall;
      default:      edge_opposite = 1'b0;        // [R13]
    endcase
  endfunction : edge_opposite

  wire valid_a = edge_valid(es_a, eif.rise[0], eif.fall[0]);
  wire valid_b = edge_valid(es_b, eif.rise[1], eif.fall[1]);
  wire opp_a   = edge_opposite(es_a, eif.rise[0], eif.fall[0]);

  // Pin clock: edges of input a count, so that input should not also trigger a capture
  wire count_tick = running & ((clk_sel == tcc_pkg::tcc_clk_pin) ? valid_a : div_tick); // [R3]

  // Both-edge selection on input a blocks register zero capture in two-register and restart modes
  wire r0_blocked = (es_a == `TCC_ES_BOTH) & (r0_reverse | mode_rstrt);     // [R13]
  wire r0_trig    = r0_reverse ? opp_a : valid_b;                           // [R10] [R12]

  wire cap_one  = running & valid_a & (r1_capture | mode_rstrt);            // [R7] [R9] [R14]
  wire cap_zero = running & r0_capture & ~r0_blocked & r0_trig;             // [R10] [R12] [R17]

  // A register with its capture select bit set never matches; its compare path is masked off
  wire match_zero = count_tick & ~r0_capture & (up_counter == capcmp_reg_zero); // [R17]
  wire match_one  = count_tick & ~r1_capture & (up_counter == capcmp_reg_one);
  wire wrap       = count_tick & (up_counter == 16'hFFFF);
  wire wrap_set   = wrap & (next_counter == `TCC_RST_WORD);

  always_comb
  begin
    next_counter = up_counter;
    if (!running)
      next_counter = `TCC_RST_WORD;
    else if (mode_rstrt && cap_one)
      next_counter = `TCC_RST_WORD;                       // [R14]
    else if (mode_clear && match_zero)
      next_counter = `TCC_RST_WORD;                       // [R1] [R2]
    else if (count_tick)
      next_counter = 16'(up_counter + 16'h0001);
  end

  // Software set/reset of the output latch wins over a match in the same cycle
  wire set_out = wr_outctl & avs_writedata[`TCC_OUT_LVS] & ~avs_writedata[`TCC_OUT_LVR];
  wire clr_out = wr_outctl & avs_writedata[`TCC_OUT_LVR] & ~avs_writedata[`TCC_OUT_LVS];
  wire tgl_out = (output_control[`TCC_OUT_TGL0] & match_zero)              // [R18] [R4]
               ^ (output_control[`TCC_OUT_TGL1] & match_one);              // [R4] [R6]

  always_comb
  begin
    next_out_ff = out_ff;
    if (set_out)
      next_out_ff = 1'b1;
    else if (clr_out)
      next_out_ff = 1'b0;
    else if (tgl_out)
      next_out_ff = ~out_ff;
  end

  // Force bits are not stored, so they read back as zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `TCC_OFS_MODE:     rd_mux = {27'h0, overflow, 2'h0, timer_mode_control};
      `TCC_OFS_CAPMODE:  rd_mux = {29'h0, capture_mode_control};
      `TCC_OFS_OUTCTL:   rd_mux = {24'h0, output_control};
      `TCC_OFS_PRESCALE: rd_mux = {24'h0, prescaler_mode};
      `TCC_OFS_CAPCMP0:  rd_mux = {16'h0, capcmp_reg_zero};
      `TCC_OFS_CAPCMP1:  rd_mux = {16'h0, capcmp_reg_one};
      `TCC_OFS_COUNTER:  rd_mux = {16'h0, up_counter};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // Reads take one wait state so read data come from a flip-flop
  assign avs_waitrequest = avs_read & ~rd_ack;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_ack       <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      rd_ack <= avs_read & ~rd_ack;
      if (avs_read && !rd_ack)
        avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_mode_control   <= 2'h0;
      capture_mode_control <= 3'h0;
      output_control       <= `TCC_RST_CTRL;
      prescaler_mode       <= `TCC_RST_CTRL;
    end
    else
    begin
      if (wr_mode)
        timer_mode_control <= avs_writedata[`TCC_MODE_MSB:`TCC_MODE_LSB];
      if (wr_capmode)
        capture_mode_control <= avs_writedata[2:0];
      if (wr_outctl)
        output_control <= avs_writedata[7:0] & `TCC_OUT_STORED_MASK;
      if (wr_prescale)
        prescaler_mode <= avs_writedata[7:0] & `TCC_PRM_STORED_MASK;
    end
  end

  // Wrap flag: a wrap in the clearing cycle still sets it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      overflow <= 1'b0;
    else if (wrap_set)
      overflow <= 1'b1;
    else if (wr_mode && !avs_writedata[`TCC_MODE_OVF])
      overflow <= 1'b0;
  end

  // A capture beats a software write landing in the same cycle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      capcmp_reg_zero <= `TCC_RST_WORD;
      capcmp_reg_one  <= `TCC_RST_WORD;
    end
    else
    begin
      if (cap_zero)
        capcmp_reg_zero <= up_counter;                    // [R10] [R12]
      else if (wr_capcmp0)
        capcmp_reg_zero <= avs_writedata[15:0];
      if (cap_one)
        capcmp_reg_one <= up_counter;                     // [R7] [R9] [R14]
      else if (wr_capcmp1)
        capcmp_reg_one <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      up_counter <= `TCC_RST_WORD;
      prediv     <= 7'h00;
      out_ff     <= 1'b0;
    end
    else
    begin
      up_counter <= next_counter;
      prediv     <= 7'(prediv + 7'h01);
      out_ff     <= next_out_ff;
    end
  end

  // Events are single-cycle, so each gives exactly one request pulse
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_capcmp_zero  <= 1'b0;
      irq_capcmp_one   <= 1'b0;
      pulse_output_pin <= 1'b0;
      pulse_output_en  <= 1'b0;
    end
    else
    begin
      irq_capcmp_zero  <= match_zero | cap_zero;           // [R1] [R10] [R19]
      irq_capcmp_one   <= match_one | cap_one;             // [R7] [R9] [R19]
      pulse_output_pin <= next_out_ff & output_control[`TCC_OUT_EN];
      pulse_output_en  <= output_control[`TCC_OUT_EN];
    end
  end

endmodule : tcc_top

// ==== verification/tcc_top_props.sv ====
`timescale 1ns/1ns

module tcc_chk (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pulse_output_pin,
  input wire logic        pulse_output_en,
  input wire logic        irq_capcmp_zero,
  input wire logic        irq_capcmp_one
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  a_read_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without a wait cycle");
  a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered in one cycle");
  a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
    else $error("waitrequest high without a read");
  a_readdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_irq_zero_pulse: assert property (irq_capcmp_zero |=> !irq_capcmp_zero)
    else $error("irq zero longer than one cycle");
  a_irq_one_pulse: assert property (irq_capcmp_one |=> !irq_capcmp_one)
    else $error("irq one longer than one cycle");
  a_pin_needs_en: assert property (pulse_output_pin |-> pulse_output_en)
    else $error("pulse output high while disabled");

  c_irq_zero: cover property (irq_capcmp_zero);
  c_irq_one: cover property (irq_capcmp_one);
  c_pin_rise: cover property ($rose(pulse_output_pin));
endmodule : tcc_chk

bind tcc_top tcc_chk u_chk (
  .clk_sys         (clk_sys),
  .nrst            (nrst),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .pulse_output_pin(pulse_output_pin),
  .pulse_output_en (pulse_output_en),
  .irq_capcmp_zero (irq_capcmp_zero),
  .irq_capcmp_one  (irq_capcmp_one)
);

// ==== verification/tcc_pulse_src.sv ====
`timescale 1ns/1ns

module tcc_pulse_src (
  input wire logic clk_sys,
  output logic     in_a,
  output logic     in_b
);
  initial {in_b, in_a} = 2'h0;

  // Called just after a rising edge; levels held whole for the given span
  task automatic step(input logic [1:0] lvl, input int hold);
    {in_b, in_a} <= lvl;
    repeat (hold) @(posedge clk_sys);
  endtask : step
endmodule : tcc_pulse_src

// ==== verification/tcc_top_tb.sv ====
`timescale 1ns/1ns
`include "tcc_defines.svh"

module tcc_top_tb;
  logic        clk_sys = 1'h0;
  logic        nrst = 1'h0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        in_a;
  logic        in_b;
  logic        pin;
  logic        pin_q;
  logic        pin_en;
  logic        irq0;
  logic        irq1;
  logic [31:0] v;
  logic [15:0] rnd = 16'h0002;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc, r0, p0, rp, pp, ph, n0, n1, nv;
  int          div[3] = '{2, 16, 128};
  logic [1:0]  es[3] = '{`TCC_ES_FALL, `TCC_ES_RISE, `TCC_ES_BOTH};

  always #5 clk_sys = ~clk_sys;

  tcc_top u_dut (
    .clk_sys         (clk_sys),
    .nrst            (nrst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .capture_input_a (in_a),
    .capture_input_b (in_b),
    .pulse_output_pin(pin),
    .pulse_output_en (pin_en),
    .irq_capcmp_zero (irq0),
    .irq_capcmp_one  (irq1)
  );
  tcc_pulse_src u_src (.clk_sys(clk_sys), .in_a(in_a), .in_b(in_b));

  // Falling edge, so updates of the rising edge have landed
  always @(negedge clk_sys)
  begin
    cyc++;
    if (irq0 === 1'h1)
    begin
      p0 = cyc - r0;
      r0 = cyc;
      n0++;
    end
    if (irq1 === 1'h1) n1++;
    if (pin === 1'h1 && pin_q !== 1'h1)
    begin
      pp = cyc - rp;
      rp = cyc;
    end
    if (pin !== 1'h1 && pin_q === 1'h1) ph = cyc - rp;
    pin_q = pin;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a falling edge, then through the next rising edge
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    logic ws;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do
    begin
      @(negedge clk_sys);
      ws = avs_waitrequest;
      v = avs_readdata;
      @(posedge clk_sys);
    end while (ws !== 1'h0);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk_sys);
  endtask : bus

  task automatic cfg(input logic [7:0] m, c, p, input logic [31:0] z);
    bus(1'h1, `TCC_OFS_MODE, 32'h0);
    bus(1'h1, `TCC_OFS_CAPMODE, {24'h0, c});
    bus(1'h1, `TCC_OFS_PRESCALE, {24'h0, p});
    bus(1'h1, `TCC_OFS_CAPCMP0, z);
    n0 = 0;
    n1 = 0;
    p0 = 0;
    pp = 0;
    ph = 0;
    bus(1'h1, `TCC_OFS_MODE, {24'h0, m});
  endtask : cfg

  task automatic diff_chk(input int d);
    logic [15:0] w;
    bus(1'h0, `TCC_OFS_CAPCMP0, 32'h0);
    w = v[15:0];
    bus(1'h0, `TCC_OFS_CAPCMP1, 32'h0);
    w = w - v[15:0];
    chk({16'h0, w}, d);
  endtask : diff_chk

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    #500000;
    err_total++;
    complete_run;
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'h1;
    @(posedge clk_sys);
    // Every register and one unmapped word read zero after reset
    for (int i = 0; i < 8; i++)
    begin
      bus(1'h0, 5'(i * 4), 32'h0);
      chk(v, 32'h0);
    end
    bus(1'h1, `TCC_OFS_PRESCALE, 32'hFF);
    bus(1'h0, `TCC_OFS_PRESCALE, 32'h0);
    chk(v, {24'h0, `TCC_PRM_STORED_MASK});
    bus(1'h1, `TCC_OFS_COUNTER, 32'hFFFF);
    bus(1'h0, `TCC_OFS_COUNTER, 32'h0);
    chk(v, 32'h0);
    for (int s = 0; s < 3; s++)
    begin
      rnd = lfsr(rnd);
      cfg(8'h02, 8'h00, 8'(s), 32'(rnd[2:0]));
      repeat ((rnd[2:0] + 1) * div[s] * 4 + 16) @(posedge clk_sys);
      chk(p0, (rnd[2:0] + 1) * div[s]);
    end
    bus(1'h1, `TCC_OFS_MODE, 32'h0);
    bus(1'h1, `TCC_OFS_CAPCMP1, 32'h3);
    // Output starts high, so it is high from the period match to the width match
    bus(1'h1, `TCC_OFS_OUTCTL, 32'h1B);
    cfg(8'h02, 8'h00, 8'h00, 32'h9);
    repeat (100) @(posedge clk_sys);
    chk(pp, 20);
    chk(ph, 8);
    chk(pin_en, 1);
    bus(1'h1, `TCC_OFS_OUTCTL, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      cfg(8'h01, 8'h05, {es[i], es[i], 4'h0}, 32'h0);
      u_src.step(2'h1, 40);
      u_src.step(2'h3, 40);
      u_src.step(2'h2, 40);
      u_src.step(2'h0, 40);
      nv = (es[i] == `TCC_ES_BOTH) ? 2 : 1;
      chk(n1, nv);
      chk(n0, nv);
      diff_chk(20);
    end
    // A one-cycle glitch is seen by at most one sample
    u_src.step(2'h1, 1);
    u_src.step(2'h0, 20);
    chk(n1, 2);
    for (int i = 1; i < 4; i += 2)
    begin
      cfg(8'h01, 8'h07, 8'(i << 4), 32'h0);
      u_src.step(2'h1, 40);
      u_src.step(2'h0, 40);
      chk(n1, (i + 1) / 2);
      chk(n0, i == 1);
      if (i == 1) diff_chk(20);
    end
    cfg(8'h03, 8'h04, 8'h10, 32'h0);
    u_src.step(2'h1, 20);
    u_src.step(2'h0, 20);
    u_src.step(2'h1, 20);
    u_src.step(2'h0, 20);
    bus(1'h0, `TCC_OFS_CAPCMP1, 32'h0);
    chk(v, 32'h13);
    // Input a edges as the count clock
    cfg(8'h01, 8'h00, 8'h13, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      u_src.step(2'h1, 20);
      u_src.step(2'h0, 20);
    end
    bus(1'h0, `TCC_OFS_COUNTER, 32'h0);
    chk(v, 32'h3);
    // Edge code 10 selects no edge at all
    cfg(8'h01, 8'h04, 8'h20, 32'h0);
    u_src.step(2'h1, 20);
    u_src.step(2'h0, 20);
    chk(n1, 0);
    // Restart mode with both edges on input a: register zero never captures
    cfg(8'h03, 8'h01, 8'hF0, 32'h0);
    u_src.step(2'h2, 20);
    u_src.step(2'h0, 20);
    chk(n0, 0);
    complete_run;
  end
endmodule : tcc_top_tb
